// ===== rtl/oasu_consts.vh
`ifndef OASU_CONSTS_VH
`define OASU_CONSTS_VH

// Operation select codes
`define OASU_OP_SLL 4'h0
`define OASU_OP_SRA 4'h1
`define OASU_OP_SRL 4'h2
`define OASU_OP_SHORT 4'h3
`define OASU_OP_IMM8 4'h4
`define OASU_OP_IMM16 4'h5
`define OASU_OP_IMM0X 4'h6
`define OASU_OP_IMM1X 4'h7
`define OASU_OP_LEGACY_BIT_ADDRESS 4'h8
`define OASU_OP_BITNAT 4'h9
`define OASU_OP_REL 4'hA
`define OASU_OP_ABS11 4'hB
`define OASU_OP_ABS16 4'hC
`define OASU_OP_ABS24 4'hD

// Short immediate encodings
`define OASU_SHORT_ONE 2'h0
`define OASU_SHORT_TWO 2'h1
`define OASU_SHORT_FOUR 2'h2

// Legacy bit map
`define OASU_BITRAM_BASE 8'h20
`define OASU_BIT_SFR_SEL 7
`define OASU_SFR_LOW_NIB 4'h8

// Native bit reach in low RAM
`define OASU_NAT_RAM_LO 16'h0020
`define OASU_NAT_RAM_HI 16'h007F

// Extra state charges
`define OASU_G1_PORT 5'h01
`define OASU_G1_SFR 5'h02
`define OASU_G2_PORT 5'h02
`define OASU_G2_SFR 5'h03
`define OASU_EXT_ADD 5'h02

// Shift sizes and timing
`define OASU_SH_BIN_BYTES 2'h3
`define OASU_SH_BIN_STATES 2'h2
`define OASU_SH_SRC_BYTES 2'h2
`define OASU_SH_SRC_STATES 2'h1

// Access kinds
`define OASU_ACC_NONE 2'h0
`define OASU_ACC_PORT 2'h1
`define OASU_ACC_SFR 2'h2
`define OASU_ACC_EXT 2'h3

`endif

// ===== rtl/oasu_state_timer.v
`timescale 1ns/1ps
// Counts the execution states of one instruction, then pulses done
module oasu_state_timer (
  input wire clk_in, // Core clock
  input wire reset_in, // Synchronous reset, high
  input wire start_in, // Load a new state count
  input wire [5:0] count_in, // Total states, at least one
  output reg busy_out, // Counting
  output reg done_out // One-cycle pulse at the final state
);
  reg [5:0] left_q;

  // Each cycle is one state; the count is never zero so done always comes
  always @(posedge clk_in) begin
    if (reset_in) begin
      left_q <= 6'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        left_q <= count_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (left_q <= 6'h01) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          left_q <= left_q - 6'h01;
        end
      end
    end
  end
endmodule // oasu_state_timer

// ===== rtl/oasu_unit.v
`timescale 1ns/1ps
`include "oasu_consts.vh"
module oasu_unit (
  input wire clk_in, // Core clock, 100 MHz
  input wire reset_in, // Synchronous reset, high
  input wire start_in, // One-cycle request strobe
  input wire [3:0] op_in, // Operation select
  input wire word_in, // Shift is on a word register
  input wire source_mode_in, // High in source mode
  input wire [15:0] byte_register_operand_in, // Byte register value in low 8 bits
  input wire [15:0] word_register_operand_in, // Word register value
  input wire [23:0] opnd_in, // Instruction operand bytes
  input wire [23:0] next_pc_in, // Address of next instruction's first byte
  input wire [1:0] acc_kind_in, // Operand access kind
  input wire group2_in, // Second logical group or word external group
  input wire [3:0] wait_n_in, // Configured wait states N
  output reg busy_out, // Instruction executing
  output reg done_out, // One-cycle pulse at completion
  output reg [31:0] result_out, // Shift result or immediate constant
  output reg [23:0] target_out, // Branch destination
  output reg [7:0] bit_byte_out, // Byte address of addressed bit
  output reg [2:0] bit_pos_out, // Bit position in that byte
  output reg bit_is_sfr_out, // Bit lives in an SFR
  output reg bit_valid_out, // Bit address within reach
  output reg [1:0] bytes_out, // Shift instruction length
  output reg [5:0] states_out, // Total execution states
  output reg carry_out // Bit shifted out
);
  wire timer_busy;
  wire timer_done;
  reg [5:0] states_d;
  reg [31:0] result_d;
  reg [23:0] target_d;
  reg [7:0] bit_byte_d;
  reg [2:0] bit_pos_d;
  reg bit_is_sfr_d;
  reg bit_valid_d;
  reg [1:0] bytes_d;
  reg carry_d;
  reg [15:0] sh_src;
  reg [5:0] base_states;
  reg [5:0] extra;
  reg hold_q;

  // Short immediate: only three legal constants, others decode to one
  function [31:0] short_val;
    input [1:0] code;
    begin
      case (code)
        `OASU_SHORT_TWO: short_val = 32'h0000_0002;
        `OASU_SHORT_FOUR: short_val = 32'h0000_0004;
        default: short_val = 32'h0000_0001;
      endcase
    end
  endfunction

  // Extra states for operand location; width kept at six bits for 2(N+2)
  function [5:0] extra_states;
    input [1:0] kind;
    input grp2;
    input [3:0] n;
    reg [5:0] ext;
    begin
      ext = {2'b00, n} + {1'b0, `OASU_EXT_ADD};
      case (kind)
        `OASU_ACC_PORT: extra_states = grp2 ? {1'b0, `OASU_G2_PORT} : {1'b0, `OASU_G1_PORT};
        `OASU_ACC_SFR: extra_states = grp2 ? {1'b0, `OASU_G2_SFR} : {1'b0, `OASU_G1_SFR};
        `OASU_ACC_EXT: extra_states = grp2 ? {ext[4:0], 1'b0} : ext;
        default: extra_states = 6'h00;
      endcase
    end
  endfunction

  oasu_state_timer u_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(start_in && !hold_q),
    .count_in(states_d),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // Decode and execute the selected operation
  always @* begin
    result_d = 32'h0000_0000;
    target_d = 24'h00_0000;
    bit_byte_d = 8'h00;
    bit_pos_d = opnd_in[2:0];
    bit_is_sfr_d = 1'b0;
    bit_valid_d = 1'b0;
    bytes_d = source_mode_in ? `OASU_SH_SRC_BYTES : `OASU_SH_BIN_BYTES;
    carry_d = 1'b0;
    sh_src = word_in ? word_register_operand_in : {8'h00, byte_register_operand_in[7:0]};
    base_states = {4'h0, source_mode_in ? `OASU_SH_SRC_STATES : `OASU_SH_BIN_STATES};
    extra = extra_states(acc_kind_in, group2_in, wait_n_in);
    case (op_in)
      `OASU_OP_SLL: begin
        // Top bit drops out, zero enters at bit zero
        result_d = word_in ? {16'h0000, sh_src[14:0], 1'b0} : {24'h00_0000, sh_src[6:0], 1'b0};
        carry_d = word_in ? sh_src[15] : sh_src[7];
      end
      `OASU_OP_SRA: begin
        result_d = word_in ? {16'h0000, sh_src[15], sh_src[15:1]} : {24'h00_0000, sh_src[7], sh_src[7:1]};
        carry_d = sh_src[0];
      end
      `OASU_OP_SRL: begin
        result_d = word_in ? {16'h0000, 1'b0, sh_src[15:1]} : {24'h00_0000, 1'b0, sh_src[7:1]};
        carry_d = sh_src[0];
      end
      `OASU_OP_SHORT: result_d = short_val(opnd_in[1:0]);
      `OASU_OP_IMM8: result_d = {24'h00_0000, opnd_in[7:0]};
      `OASU_OP_IMM16: result_d = {16'h0000, opnd_in[15:0]};
      `OASU_OP_IMM0X: result_d = {16'h0000, opnd_in[15:0]};
      `OASU_OP_IMM1X: result_d = {16'hFFFF, opnd_in[15:0]};
      `OASU_OP_LEGACY_BIT_ADDRESS: begin
        bit_valid_d = 1'b1;
        if (opnd_in[`OASU_BIT_SFR_SEL]) begin
          // Upper half: SFR byte is bit number with low three bits cleared
          bit_is_sfr_d = 1'b1;
          bit_byte_d = {opnd_in[7:3], 3'b000};
        end else begin
          bit_byte_d = `OASU_BITRAM_BASE + {4'h0, opnd_in[6:3]};
        end
      end
      `OASU_OP_BITNAT: begin
        // opnd[23] selects SFR space, opnd[15:8] is byte address
        bit_byte_d = opnd_in[15:8];
        bit_is_sfr_d = opnd_in[23];
        bit_valid_d = opnd_in[23] ||
          ({8'h00, opnd_in[15:8]} >= `OASU_NAT_RAM_LO && {8'h00, opnd_in[15:8]} <= `OASU_NAT_RAM_HI);
      end
      `OASU_OP_REL: target_d = next_pc_in + {{16{opnd_in[7]}}, opnd_in[7:0]};
      `OASU_OP_ABS11: target_d = {next_pc_in[23:11], opnd_in[10:0]};
      `OASU_OP_ABS16: target_d = {next_pc_in[23:16], opnd_in[15:0]};
      `OASU_OP_ABS24: target_d = opnd_in;
      default: result_d = 32'h0000_0000;
    endcase
    // Requests are refused while busy, so timing always reflects the latched op
    states_d = base_states + extra;
  end

  // Latch results at acceptance; outputs stand until the next accepted request
  always @(posedge clk_in) begin
    if (reset_in) begin
      hold_q <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      result_out <= 32'h0000_0000;
      target_out <= 24'h00_0000;
      bit_byte_out <= 8'h00;
      bit_pos_out <= 3'h0;
      bit_is_sfr_out <= 1'b0;
      bit_valid_out <= 1'b0;
      bytes_out <= 2'h0;
      states_out <= 6'h00;
      carry_out <= 1'b0;
    end else begin
      done_out <= timer_done;
      busy_out <= (start_in && !hold_q) || (timer_busy && !timer_done);
      if (start_in && !hold_q) begin
        hold_q <= 1'b1;
        result_out <= result_d;
        target_out <= target_d;
        bit_byte_out <= bit_byte_d;
        bit_pos_out <= bit_pos_d;
        bit_is_sfr_out <= bit_is_sfr_d;
        bit_valid_out <= bit_valid_d;
        bytes_out <= bytes_d;
        states_out <= states_d;
        carry_out <= carry_d;
      end else if (timer_done) begin
        hold_q <= 1'b0;
      end
    end
  end
endmodule // oasu_unit

// ===== tb/oasu_prog_mem.sv
`timescale 1ns/1ps
// Program memory model: operand bytes and next-instruction address per slot
module oasu_prog_mem (
  input wire logic [3:0] slot_in, // Instruction slot
  output logic [23:0] opnd_out, // Operand bytes
  output logic [23:0] next_pc_out // First byte of following instruction
);
  logic [23:0] opnd_mem [16];
  logic [23:0] pc_mem [16];
  // Bench plants the contents so corner operands can be placed anywhere
  assign opnd_out = opnd_mem[slot_in];
  assign next_pc_out = pc_mem[slot_in];
endmodule // oasu_prog_mem

// ===== tb/oasu_unit_chk.sv
`timescale 1ns/1ps
`include "oasu_consts.vh"
module oasu_chk (
  input wire logic clk_in, reset_in, start_in, word_in, source_mode_in, group2_in, busy_out, done_out,
  input wire logic [1:0] acc_kind_in,
  input wire logic [3:0] op_in, wait_n_in,
  input wire logic [15:0] word_register_operand_in,
  input wire logic [23:0] opnd_in, next_pc_in, target_out,
  input wire logic [31:0] result_out,
  input wire logic [5:0] states_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire take = start_in && !busy_out;
  wire [15:0] sra_t = {word_register_operand_in[15], word_register_operand_in[15:1]};
  wire [23:0] rel_t = next_pc_in + {{16{opnd_in[7]}}, opnd_in[7:0]};
  wire [23:0] blk_t = {next_pc_in[23:11], opnd_in[10:0]};
  logic [5:0] cnt_q, st;
  // States owed by a request presented now
  always_comb begin
    st = source_mode_in ? 6'h01 : 6'h02;
    case (acc_kind_in)
      2'h1: st = st + 6'h01 + group2_in;
      2'h2: st = st + 6'h02 + group2_in;
      2'h3: st = st + ((wait_n_in + 6'h02) << group2_in);
      default: st = st;
    endcase
  end
  // Cycles since the last accepted request; saturates so it cannot wrap
  always_ff @(posedge clk_in) cnt_q <= reset_in ? 6'h00 : take ? 6'h01 : cnt_q + (cnt_q != 6'h3f);
  property p_st; take |=> states_out == $past(st); endproperty
  a_st: assert property (p_st) else $error("state count wrong");
  property p_done; done_out |-> cnt_q == states_out + 6'h02; endproperty
  a_done: assert property (p_done) else $error("done at wrong cycle");
  property p_bound; take |-> ##[2:40] done_out; endproperty
  a_bound: assert property (p_bound) else $error("done missing");
  property p_busy; busy_out |-> !done_out && cnt_q <= states_out + 6'h01; endproperty
  a_busy: assert property (p_busy) else $error("busy too long");
  property p_sra; take && op_in == `OASU_OP_SRA && word_in |=> result_out[15:0] == $past(sra_t); endproperty
  a_sra: assert property (p_sra) else $error("word arith shift wrong");
  property p_short; take && op_in == `OASU_OP_SHORT |=> $onehot(result_out) && result_out < 32'h8; endproperty
  a_short: assert property (p_short) else $error("short constant wrong");
  property p_rel; take && op_in == `OASU_OP_REL |=> target_out == $past(rel_t); endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_blk; take && op_in == `OASU_OP_ABS11 |=> target_out == $past(blk_t); endproperty
  a_blk: assert property (p_blk) else $error("block target wrong");
endmodule // oasu_chk
bind oasu_unit oasu_chk oasu_chk_inst (.*);

// ===== tb/operand_addressing_shift_unit_bench.sv
`timescale 1ns/1ps
module operand_addressing_shift_unit_bench;
  logic clk_in = 0, reset_in = 1, start_in = 0, word_in = 0, source_mode_in = 0, group2_in = 0;
  logic [3:0] op_in = 0, wait_n_in = 0, slot = 0;
  logic [1:0] acc_kind_in = 0;
  logic [15:0] byte_register_operand_in = 0, word_register_operand_in = 0;
  wire [23:0] opnd_in, next_pc_in, target_out;
  wire busy_out, done_out, bit_is_sfr_out, bit_valid_out, carry_out;
  wire [31:0] result_out;
  wire [7:0] bit_byte_out;
  wire [2:0] bit_pos_out;
  wire [1:0] bytes_out;
  wire [5:0] states_out;
  integer seed = 5412, miscompares = 0, check_count = 0, i, r;
  always #5 clk_in = ~clk_in;
  oasu_prog_mem oasu_prog_mem_inst (.slot_in(slot), .opnd_out(opnd_in), .next_pc_out(next_pc_in));
  oasu_unit oasu_unit_inst (.*);
  task chk(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Total states: mode base plus access charge
  function logic [5:0] exp_st(input logic s, g, input logic [1:0] a, input logic [3:0] n);
    exp_st = s ? 6'h01 : 6'h02;
    if (a == 2'h1) exp_st += 6'h01 + g;
    if (a == 2'h2) exp_st += 6'h02 + g;
    if (a == 2'h3) exp_st += (n + 6'h02) << g;
  endfunction
  // One request, a refused second strobe while busy, then all checks
  task run(input logic [3:0] op, input logic wd, s, g, input logic [1:0] a, input logic [3:0] n, sl);
    int k;
    logic [15:0] v;
    logic [31:0] m, e;
    logic [23:0] o, p;
    {op_in, word_in, source_mode_in, group2_in, acc_kind_in, wait_n_in, slot} = {op, wd, s, g, a, n, sl};
    byte_register_operand_in = $random(seed);
    word_register_operand_in = $random(seed);
    start_in = 1;
    @(posedge clk_in);
    #1 op_in = op ^ 4'h1;
    @(posedge clk_in);
    #1 start_in = 0;
    for (k = 0; k < 50 && done_out !== 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    if (k == 50) begin
      miscompares++;
      report_and_stop;
    end
    o = opnd_in;
    p = next_pc_in;
    v = wd ? word_register_operand_in : {8'h00, byte_register_operand_in[7:0]};
    m = wd ? 32'h0000_ffff : 32'h0000_00ff;
    chk(states_out, exp_st(s, g, a, n));
    case (op)
      4'h0, 4'h1, 4'h2: begin
        e = op == 4'h0 ? v << 1 : op == 4'h2 ? v >> 1 : wd ? {v[15], v[15:1]} : {v[7], v[7:1]};
        chk(result_out & m, e & m);
        chk(bytes_out, s ? 2'h2 : 2'h3);
        chk(carry_out, op == 4'h0 ? (wd ? v[15] : v[7]) : v[0]);
      end
      4'h3: chk(result_out, o[1:0] == 2'h1 ? 32'h2 : o[1:0] == 2'h2 ? 32'h4 : 32'h1);
      4'h4: chk(result_out, o[7:0]);
      4'h5, 4'h6: chk(result_out, o[15:0]);
      4'h7: chk(result_out, {16'hffff, o[15:0]});
      4'h8: chk({bit_is_sfr_out, bit_byte_out, bit_pos_out}, {o[7], o[7] ? {o[7:3], 3'h0} : 8'h20 + o[6:3], o[2:0]});
      4'h9: chk({bit_valid_out, bit_is_sfr_out, bit_byte_out, bit_pos_out},
        {o[23] | (o[15:8] >= 8'h20 && o[15:8] <= 8'h7f), o[23], o[15:8], o[2:0]});
      4'ha: chk(target_out, 24'(p + {{16{o[7]}}, o[7:0]}));
      4'hb: chk(target_out, {p[23:11], o[10:0]});
      4'hc: chk(target_out, {p[23:16], o[15:0]});
      default: chk(target_out, o);
    endcase
  endtask
  initial begin
    for (i = 0; i < 16; i++) begin
      oasu_prog_mem_inst.opnd_mem[i] = $random(seed);
      oasu_prog_mem_inst.pc_mem[i] = $random(seed);
    end
    // Edge operands: most negative and positive offsets, bit range ends, block and space ends
    oasu_prog_mem_inst.opnd_mem[0] = 24'h00_0080;
    oasu_prog_mem_inst.opnd_mem[1] = 24'h80_7f7f;
    oasu_prog_mem_inst.opnd_mem[2] = 24'h00_2003;
    oasu_prog_mem_inst.pc_mem[0] = 24'hff_ffff;
    oasu_prog_mem_inst.pc_mem[1] = 24'h00_07ff;
    repeat (20) @(posedge clk_in);
    #1 reset_in = 0;
    for (i = 0; i < 84; i++) run(i % 14, i[0], i[4], i[2], i[1:0], i[3] ? 4'hf : 4'h0, i % 3);
    // Mid-run reset clears every latched output before random traffic resumes
    reset_in = 1;
    repeat (2) @(posedge clk_in);
    #1 reset_in = 0;
    chk({busy_out, done_out, states_out, bytes_out, carry_out}, 0);
    chk(result_out, 0);
    chk(target_out, 0);
    chk({bit_byte_out, bit_pos_out, bit_is_sfr_out, bit_valid_out}, 0);
    for (i = 0; i < 200; i++) begin
      r = $random(seed);
      run(r[3:0] % 4'he, r[4], r[5], r[6], r[8:7], r[12:9], r[16:13]);
    end
    report_and_stop;
  end
endmodule // operand_addressing_shift_unit_bench
